// *** adc_powerup_sequential_timing_bench.sv ***
/*
 * self-checking bench for the converter sequencer.
 * assumes a 25 MHz clock; inputs change on the falling edge only.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_powerup_sequential_timing_bench
	import conv_ctl_pkg::*;
;
	logic clk = 1'h0, rst_b = 1'h0, pwr_req = 1'h0, together = 1'h0;
	logic dual = 1'h0, cont = 1'h0, sw = 1'h0, pwm = 1'h0, ext = 1'h0;
	logic fclr = 1'h0, rdy = 1'h1;
	logic [3:0] acq = 4'h0, ch = 4'h0;
	logic [11:0] ana_a = 12'h000, ana_b = 12'h000;
	logic [1:0] bgr;
	logic core_on, pwr_done, sh, rflag, ready, busy, rvalid;
	logic [3:0] ach, rch;
	logic [11:0] rreg;
	result_t rdata, exp_item;
	result_t exp_q[$];
	int error_cnt = 0, checks = 0, seed;

	always #20 clk = ~clk;

	power_sw_model #(.BGR_WAIT(20), .PWD_WAIT(10)) i_sw (.clk_i(clk),
		.power_req_i(pwr_req), .together_i(together), .bgr_o(bgr),
		.core_o(core_on), .done_o(pwr_done));

	conv_sequencer #(.BGR_CYCLES(20), .PWD_CYCLES(10)) i_dut (.CORE_CLK_I(clk),
		.RST_B_I(rst_b), .BANDGAP_REF_POWER_BITS_I(bgr), .CORE_POWER_ON_BIT_I(core_on),
		.DUAL_SAMPLE_SELECT_I(dual), .ACQ_WINDOW_I(acq), .CHANNEL_SEL_I(ch),
		.CONTINUOUS_I(cont), .SW_TRIGGER_I(sw), .PWM_TRIGGER_I(pwm),
		.EXTERNAL_CONVERSION_START_I(ext), .FLAG_CLEAR_I(fclr),
		.ANALOG_A_I(ana_a), .ANALOG_B_I(ana_b), .SAMPLE_HOLD_O(sh),
		.ANALOG_CHANNEL_O(ach), .RESULT_REG_O(rreg), .RESULT_CH_O(rch),
		.CONV_FLAG_O(rflag), .READY_O(ready), .BUSY_O(busy),
		.RESULT_VALID_O(rvalid), .RESULT_READY_I(rdy), .RESULT_DATA_O(rdata));

	// ------------------------------------------------------------
	// result watcher: oldest note against each popped word
	// ------------------------------------------------------------
	always @(posedge clk)
		if (rst_b && rvalid === 1'b1 && rdy)
		begin
			`CHK(exp_q.size() != 0, 1'b1)
			exp_item = (exp_q.size() != 0) ? exp_q.pop_front() : rdata;
			`CHK(rdata, exp_item)
		end

	task automatic finish_test();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic give_up();
		error_cnt++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		finish_test();
	endtask

	// trigger pulses are dropped here, so callers only raise them
	task automatic wait_sh(input int lim, output int n);
		n = 0;
		while (sh !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
			if (n == 1)
				{sw, pwm} = 2'h0;
			if (n == 4)
				ext = 1'h0;
		end
		if (sh !== 1'b1)
			give_up();
	endtask

	task automatic conv(input int src, input logic [3:0] a, input logic [3:0] c,
		input logic d);
		int n, w;
		logic [11:0] ka, kb;
		ka = 12'($urandom);
		kb = 12'($urandom);
		{acq, ch, dual} = {a, c, d};
		{ana_a, ana_b} = {~ka, ~kb};
		fclr = 1'h1;
		@(negedge clk);
		fclr = 1'h0;
		if (d)
		begin
			exp_q.push_back(result_t'({c & 4'h7, ka}));
			exp_q.push_back(result_t'({c | 4'h8, kb}));
		end
		else
			exp_q.push_back(result_t'({c, ka}));
		{sw, pwm, ext} = {src == 0, src == 1, src == 2};
		wait_sh(30, n);
		`CHK(n, (src == 2) ? 8 : 5)
		`CHK(busy, 1'b1)
		if (!d) `CHK(ach, c)
		w = 0;
		while (sh === 1'b1 && w < 40)
		begin
			w++;
			// decoys around the last pulse cycles expose an early capture
			if (w == 2 * (1 + int'(a)) - 1)
				{ana_a, ana_b} = {ka, kb};
			@(negedge clk);
		end
		`CHK(w, 2 * (1 + int'(a)))
		{ana_a, ana_b} = {~ka, ~kb};
		repeat (8) @(negedge clk);
		`CHK(rreg, ka)
		`CHK(rch, d ? (c & 4'h7) : c)
		@(negedge clk);
		if (!d) `CHK(rflag, 1'b0)
		@(negedge clk);
		`CHK(rflag, 1'b1)
		if (d) `CHK({rch, rreg}, {c | 4'h8, kb})
		repeat (4) @(negedge clk);
		`CHK(busy, 1'b0)
	endtask

	task automatic power_up();
		int n;
		pwr_req = 1'h1;
		n = 0;
		while (ready !== 1'b1 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		// ready rises half a cycle before done, which is set on the falling edge that first sees ready
		@(negedge clk);
		`CHK(ready, 1'b1)
		`CHK(pwr_done, 1'b1)
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		int n, rises, t0, t1, k;
		logic p;
		seed = $urandom(97013);
		repeat (12) @(negedge clk);
		rst_b = 1'h1;
		power_up();
		$display("test power_up_ordered done");

		for (int i = 0; i < 16; i++)
			conv(i % 3, (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom), 4'(i), 1'b0);
		$display("test single_channel_sweep done");
		for (int i = 0; i < 2; i++)
			conv(i, 4'($urandom), 4'($urandom), 1'b1);
		$display("test paired_mode done");

		// back-pressure: four results fit, then the sequencer must stall
		acq = 4'($urandom);
		k = $urandom;
		ana_a = 12'(k);
		{dual, cont, rdy, sw} = 4'b0101;
		wait_sh(30, n);
		{rises, t0, t1, p} = {32'd1, 32'd0, 32'd0, 1'b1};
		for (int i = 1; i < 300; i++)
		begin
			@(negedge clk);
			if (sh === 1'b1 && !p)
			begin
				rises++;
				if (rises == 2)
					t1 = i;
			end
			p = sh;
		end
		`CHK(t1 - t0, 2 * (2 + int'(acq)))
		`CHK(rises, FIFO_DEPTH)
		`CHK(rvalid, 1'b1)
		cont = 1'h0;
		repeat (FIFO_DEPTH) exp_q.push_back(result_t'({ch, 12'(k)}));
		for (int i = 0; i < 200 && (exp_q.size() != 0 || rvalid); i++)
		begin
			@(negedge clk);
			rdy = 1'($urandom);
		end
		rdy = 1'h1;
		repeat (20) @(negedge clk);
		`CHK(exp_q.size(), 0)
		`CHK(rvalid, 1'b0)
		$display("test continuous_backpressure done");

		pwr_req = 1'h0;
		repeat (3) @(negedge clk);
		{sw, pwm} = 2'h3;
		n = 0;
		repeat (30)
		begin
			@(negedge clk);
			{sw, pwm} = 2'h0;
			n += int'(sh === 1'b1);
		end
		`CHK(n, 0)
		$display("test trigger_unpowered done");

		together = 1'h1;
		power_up();
		conv(2, 4'h3, 4'h9, 1'b0);
		$display("test power_up_together done");
		finish_test();
	end
endmodule
`default_nettype wire

// *** conv_ctl_pkg.sv ***
/*
 * constants and carrier types for the converter sequencing block.
 * assumes a 25 MHz system clock; the converter clock is derived
 * from it as an enable pulse, never as a separate clock.
 */
`default_nettype none
package conv_ctl_pkg;
	// ----------------------------------------------------------------
	// clock and settling times
	// ----------------------------------------------------------------
	localparam int CLK_KHZ           = 25000;
	localparam int BGR_SETTLE_MS     = 5;
	localparam int BGR_SETTLE_CYCLES = BGR_SETTLE_MS * CLK_KHZ;
	localparam int PWD_SETTLE_US     = 1000;
	localparam int PWD_SETTLE_CYCLES = (PWD_SETTLE_US * CLK_KHZ) / 1000;
	localparam int SETTLE_W          = 17;
	// converter clock half period in system cycles (12.5 MHz converter clock)
	localparam int CONV_HALF_CYCLES  = 1;
	localparam int DIV_W             = 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_HALF_CYCLES - 1);

	// ----------------------------------------------------------------
	// sequencing counts, in converter half periods
	// ----------------------------------------------------------------
	localparam logic [5:0] TRIG_DELAY_HALVES = 6'h05;
	localparam logic [5:0] GAP_SEQ_HALVES    = 6'h02;
	localparam logic [5:0] GAP_DUAL_HALVES   = 6'h04;
	localparam logic [5:0] HALVES_ONE        = 6'h01;
	localparam logic [3:0] RESULT_A_HALVES   = 4'h8;
	localparam logic [3:0] RESULT_B_GAP      = 4'h2;

	// ----------------------------------------------------------------
	// widths, depths and delays
	// ----------------------------------------------------------------
	localparam int DATA_W     = 12;
	localparam int CH_W       = 4;
	localparam int ACQ_W      = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int LVL_W      = 3;
	localparam int PIPE_SLOTS = 4;
	localparam int FLAG_DELAY = 2;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_HOLD, ST_GAP} seq_state_t;

	typedef struct packed {
		logic [CH_W-1:0]   channel;
		logic [DATA_W-1:0] data;
	} result_t;

	typedef struct packed {
		logic              valid;
		logic              pair;
		logic              b_phase;
		logic [3:0]        halves;
		logic [CH_W-1:0]   channel;
		logic [DATA_W-1:0] data_a;
		logic [DATA_W-1:0] data_b;
	} pipe_slot_t;
endpackage
`default_nettype wire

// *** conv_sequencer.sv ***
/*
 * converter control: power-up settling, trigger selection, sample/hold
 * pulse timing, result latency, result fifo and delayed done flag.
 * assumes the analog core presents converted codes on the a/b inputs,
 * same clock; the external start pin is asynchronous.
 */
// Overview of operation
// - all three power bits may be set together; bandgap delay then applies.
// - sixteen input channels selected by software, single or paired.
// - each conversion yields a 12-bit result.
// - dual sample select 0 is sequential, 1 is simultaneous paired sampling.
// - pwm event, software or external start pin can start a conversion.
// - sequential mode converts selected channel each pulse, optionally continuously.
// - input sampled at the falling edge of the sample/hold pulse.
// - sample/hold pulse lasts one plus acquisition field converter clocks.
// - sampling pulse begins 2.5 converter clocks after the trigger.
// - first result appears 4 converter clocks after sampling.
// - successive sequential-mode results spaced two plus acquisition field converter clocks.
// - done flag set a few system cycles after the result update.
`timescale 1ns/100ps
`default_nettype none
module conv_sequencer
	import conv_ctl_pkg::*;
#(
	parameter int BGR_CYCLES = BGR_SETTLE_CYCLES,
	parameter int PWD_CYCLES = PWD_SETTLE_CYCLES
)(
	input  wire logic              CORE_CLK_I,
	input  wire logic              RST_B_I,
	input  wire logic [1:0]        BANDGAP_REF_POWER_BITS_I,
	input  wire logic              CORE_POWER_ON_BIT_I,
	input  wire logic              DUAL_SAMPLE_SELECT_I,
	input  wire logic [ACQ_W-1:0]  ACQ_WINDOW_I,
	input  wire logic [CH_W-1:0]   CHANNEL_SEL_I,
	input  wire logic              CONTINUOUS_I,
	input  wire logic              SW_TRIGGER_I,
	input  wire logic              PWM_TRIGGER_I,
	input  wire logic              EXTERNAL_CONVERSION_START_I,
	input  wire logic              FLAG_CLEAR_I,
	input  wire logic [DATA_W-1:0] ANALOG_A_I,
	input  wire logic [DATA_W-1:0] ANALOG_B_I,
	output logic                   SAMPLE_HOLD_O,
	output logic [CH_W-1:0]        ANALOG_CHANNEL_O,
	output logic [DATA_W-1:0]      RESULT_REG_O,
	output logic [CH_W-1:0]        RESULT_CH_O,
	output logic                   CONV_FLAG_O,
	output logic                   READY_O,
	output logic                   BUSY_O,
	output logic                   RESULT_VALID_O,
	input  wire logic              RESULT_READY_I,
	output result_t                RESULT_DATA_O
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_state_t                  st;
		logic [5:0]                  cnt;
		logic                        sh;
		logic                        smp;
		logic                        chain;
		logic [ACQ_W-1:0]            acq;
		logic                        dual;
		logic [CH_W-1:0]             ch;
		pipe_slot_t [PIPE_SLOTS-1:0] pipe;
		logic [DATA_W-1:0]           result;
		logic [CH_W-1:0]             result_ch;
		logic                        res_upd;
		logic [FLAG_DELAY-1:0]       flag_dly;
		logic                        flag;
		logic [2:0]                  ext_sync;
		logic                        ext_lvl;
		logic [SETTLE_W-1:0]         bgr_cnt;
		logic                        bgr_ok;
		logic [SETTLE_W-1:0]         pwd_cnt;
		logic                        pwd_ok;
		logic [DIV_W-1:0]            div;
		logic [5:0]                  sh_len;
		logic [6:0]                  smp_gap;
	} ctl_state_t;

	ctl_state_t  cs;
	ctl_state_t  next_cs;
	logic        tick;
	logic        ext_edge;
	logic        power;
	logic        room;
	logic        accept;
	logic        fire;
	result_t     fire_data;
	logic        fifo_ready;
	logic [LVL_W-1:0] fifo_level;
	logic [3:0]  pending;
	logic [3:0]  need;

	function automatic logic [3:0] count_pending(input pipe_slot_t [PIPE_SLOTS-1:0] p);
		logic [3:0] n;
		n = '0;
		for (int i = 0; i < PIPE_SLOTS; i++)
		begin
			if (p[i].valid)
				n = n + 4'h1 + 4'(p[i].pair && !p[i].b_phase);
		end
		return n;
	endfunction

	function automatic logic [5:0] hold_halves(input logic [ACQ_W-1:0] acq);
		return (6'(acq) + HALVES_ONE) << 1;
	endfunction

	assign power    = CORE_POWER_ON_BIT_I;
	assign tick     = (cs.div == DIV_LAST);
	assign ext_edge = cs.ext_sync[1] && cs.ext_sync[2] && !cs.ext_lvl;
	assign pending  = count_pending(cs.pipe);
	assign need     = DUAL_SAMPLE_SELECT_I ? 4'h2 : 4'h1;
	// refuse new samples unless every result in flight has a fifo slot
	assign room     = (4'(fifo_level) + pending + need) <= 4'(FIFO_DEPTH);
	assign accept   = (SW_TRIGGER_I || PWM_TRIGGER_I || ext_edge)
		&& power && room && (cs.st == ST_IDLE);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic go_hold;
		logic placed;
		go_hold   = 1'b0;
		placed    = 1'b0;
		fire      = 1'b0;
		fire_data = '0;
		next_cs   = cs;
		next_cs.smp     = 1'b0;
		next_cs.res_upd = 1'b0;
		next_cs.div = tick ? '0 : cs.div + 1'b1;

		// external start pin: three stages, change counted when 2 and 3 agree
		next_cs.ext_sync = {cs.ext_sync[1:0], EXTERNAL_CONVERSION_START_I};
		if (cs.ext_sync[1] == cs.ext_sync[2])
			next_cs.ext_lvl = cs.ext_sync[2];

		// counters run side by side, so writing all bits at once works
		if (BANDGAP_REF_POWER_BITS_I != 2'b11)
		begin
			next_cs.bgr_cnt = '0;
			next_cs.bgr_ok  = 1'b0;
		end
		else if (cs.bgr_cnt == SETTLE_W'(BGR_CYCLES - 1))
			next_cs.bgr_ok = 1'b1;
		else
			next_cs.bgr_cnt = cs.bgr_cnt + 1'b1;
		if (!power)
		begin
			next_cs.pwd_cnt = '0;
			next_cs.pwd_ok  = 1'b0;
		end
		else if (cs.pwd_cnt == SETTLE_W'(PWD_CYCLES - 1))
			next_cs.pwd_ok = 1'b1;
		else
			next_cs.pwd_cnt = cs.pwd_cnt + 1'b1;

		// result pipeline, one result at most per cycle
		for (int i = 0; i < PIPE_SLOTS; i++)
		begin
			if (cs.pipe[i].valid && tick)
			begin
				if (cs.pipe[i].halves == 4'h1)
				begin
					fire = 1'b1;
					fire_data.channel = cs.pipe[i].b_phase ?
						{1'b1, cs.pipe[i].channel[CH_W-2:0]} : cs.pipe[i].channel;
					fire_data.data = cs.pipe[i].b_phase ? cs.pipe[i].data_b : cs.pipe[i].data_a;
					if (cs.pipe[i].pair && !cs.pipe[i].b_phase)
					begin
						next_cs.pipe[i].b_phase = 1'b1;
						next_cs.pipe[i].halves  = RESULT_B_GAP;
					end
					else
						next_cs.pipe[i].valid = 1'b0;
				end
				else
					next_cs.pipe[i].halves = cs.pipe[i].halves - 4'h1;
			end
		end
		if (fire)
		begin
			next_cs.result    = fire_data.data;
			next_cs.result_ch = fire_data.channel;
			next_cs.res_upd   = 1'b1;
		end

		// flag follows the result by a short fixed delay; set wins
		// fed from the update made this cycle, so the flag lands FLAG_DELAY after the result
		next_cs.flag_dly = {cs.flag_dly[FLAG_DELAY-2:0], next_cs.res_upd};
		next_cs.flag = cs.flag_dly[FLAG_DELAY-1] || (cs.flag && !FLAG_CLEAR_I);

		unique case (cs.st)
			ST_IDLE:
			begin
				// 2.5 converter clocks counted in half periods
				if (accept)
				begin
					next_cs.st  = ST_DELAY;
					next_cs.cnt = TRIG_DELAY_HALVES - HALVES_ONE;
				end
			end
			ST_DELAY:
			begin
				if (tick && cs.cnt == HALVES_ONE)
					go_hold = 1'b1;
				else if (tick)
					next_cs.cnt = cs.cnt - HALVES_ONE;
			end
			ST_HOLD:
			begin
				if (tick && cs.cnt == HALVES_ONE)
				begin
					// capture on the falling edge of the pulse
					next_cs.sh  = 1'b0;
					next_cs.smp = 1'b1;
					next_cs.st  = ST_GAP;
					next_cs.cnt = cs.dual ? GAP_DUAL_HALVES : GAP_SEQ_HALVES;
					for (int i = 0; i < PIPE_SLOTS; i++)
					begin
						if (!cs.pipe[i].valid && !placed)
						begin
							placed = 1'b1;
							next_cs.pipe[i].valid   = 1'b1;
							next_cs.pipe[i].pair    = cs.dual;
							next_cs.pipe[i].b_phase = 1'b0;
							next_cs.pipe[i].halves  = RESULT_A_HALVES;
							next_cs.pipe[i].channel = cs.ch;
							next_cs.pipe[i].data_a  = ANALOG_A_I;
							next_cs.pipe[i].data_b  = ANALOG_B_I;
						end
					end
				end
				else if (tick)
					next_cs.cnt = cs.cnt - HALVES_ONE;
			end
			ST_GAP:
			begin
				// one clock gap (two in paired mode) keeps successive sequential results 2 + acq apart
				// continuous conversion restarts without a trigger
				if (tick && cs.cnt == HALVES_ONE)
				begin
					if (CONTINUOUS_I && room)
					begin
						go_hold = 1'b1;
						next_cs.chain = 1'b1;
					end
					else if (CONTINUOUS_I)
						next_cs.chain = 1'b0;
					else
						next_cs.st = ST_IDLE;
				end
				else if (tick)
					next_cs.cnt = cs.cnt - HALVES_ONE;
			end
		endcase

		if (go_hold)
		begin
			// width of 1 + acquisition field converter clocks
			next_cs.st   = ST_HOLD;
			next_cs.sh   = 1'b1;
			next_cs.acq  = ACQ_WINDOW_I;
			next_cs.cnt  = hold_halves(ACQ_WINDOW_I);
			// paired mode samples channel n and n + 8 together
			next_cs.dual = DUAL_SAMPLE_SELECT_I;
			next_cs.ch   = DUAL_SAMPLE_SELECT_I ? {1'b0, CHANNEL_SEL_I[CH_W-2:0]} : CHANNEL_SEL_I;
			if (cs.st == ST_DELAY || ACQ_WINDOW_I != cs.acq || DUAL_SAMPLE_SELECT_I != cs.dual)
				next_cs.chain = 1'b0;
		end
		if (cs.st == ST_IDLE)
			next_cs.chain = 1'b0;

		// losing core power aborts the sequence at once
		if (!power)
		begin
			next_cs.st    = ST_IDLE;
			next_cs.sh    = 1'b0;
			next_cs.smp   = 1'b0;
			next_cs.chain = 1'b0;
		end

		// checking helpers
		next_cs.sh_len  = cs.sh ? cs.sh_len + 6'h01 : 6'h00;
		// restarts one cycle after a sample, so it holds the full spacing at the next one
		next_cs.smp_gap = cs.smp ? 7'h01 : ((cs.smp_gap == 7'h7F) ? cs.smp_gap : cs.smp_gap + 7'h01);
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			cs    <= '0;
			cs.st <= ST_IDLE;
		end
		else
			cs <= next_cs;
	end

	// ----------------------------------------------------------------
	// result fifo
	// ----------------------------------------------------------------
	// twelve-bit codes travel with their channel
	result_fifo #(
		.WIDTH ($bits(result_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CORE_CLK_I),
		.rst_b_i     (RST_B_I),
		.in_valid_i  (fire),
		.in_ready_o  (fifo_ready),
		.in_data_i   (fire_data),
		.out_valid_o (RESULT_VALID_O),
		.out_ready_i (RESULT_READY_I),
		.out_data_o  (RESULT_DATA_O),
		.level_o     (fifo_level)
	);

	assign SAMPLE_HOLD_O    = cs.sh;
	assign ANALOG_CHANNEL_O = cs.ch;
	assign RESULT_REG_O     = cs.result;
	assign RESULT_CH_O      = cs.result_ch;
	assign CONV_FLAG_O      = cs.flag;
	// ready is advisory only; conversions are gated by the power bit alone
	assign READY_O          = cs.bgr_ok && cs.pwd_ok;
	assign BUSY_O           = (cs.st != ST_IDLE) || (pending != 4'h0);

	// ----------------------------------------------------------------
	// checks (written for a half period of one system cycle)
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);

	chk_trig_delay: assert property (accept |-> ##5 ($rose(SAMPLE_HOLD_O) || !power))
		else $error("sample pulse not 2.5 converter clocks after trigger");
	chk_hold_width: assert property ($fell(cs.sh) && cs.smp |-> cs.sh_len == hold_halves(cs.acq))
		else $error("sample pulse width wrong");
	chk_first_result: assert property (cs.smp |-> ##8 cs.res_upd)
		else $error("first result not 4 converter clocks after sampling");
	chk_pair_second: assert property (cs.smp && cs.dual |-> ##10 cs.res_upd)
		else $error("paired second result late");
	chk_seq_spacing: assert property (cs.smp && cs.chain && !cs.dual |->
		cs.smp_gap == 7'(hold_halves(cs.acq)) + 7'h02)
		else $error("successive samples wrongly spaced");
	chk_power_gate: assert property (!power |=> !cs.sh && cs.st == ST_IDLE)
		else $error("sequence runs without core power");
	chk_flag_delay: assert property (cs.res_upd |-> ##2 cs.flag)
		else $error("done flag not set after result update");
	chk_sample_edge: assert property (cs.smp |-> $past(cs.sh) && !cs.sh)
		else $error("sample not at falling edge");
	chk_fifo_room: assert property (fire |-> fifo_ready)
		else $error("result pushed into a full fifo");
	chk_ready_gate: assert property (READY_O |-> $past(power && BANDGAP_REF_POWER_BITS_I == 2'b11))
		else $error("ready without all power bits");
endmodule
`default_nettype wire

// *** power_sw_model.sv ***
/*
 * partner model: the controlling software side of converter power-up.
 * assumes the block samples the power bits on the rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module power_sw_model #(
	parameter int BGR_WAIT = 20,
	parameter int PWD_WAIT = 10
)(
	input  wire logic       clk_i,
	input  wire logic       power_req_i,
	input  wire logic       together_i,
	output logic [1:0]      bgr_o,
	output logic            core_o,
	output logic            done_o
);
	// ------------------------------------------------------------
	// power sequencing
	// ------------------------------------------------------------
	// one process owns all three outputs; a drop is only honoured after power-up ends
	initial
	begin
		bgr_o  = 2'h0;
		core_o = 1'h0;
		done_o = 1'h0;
		forever
		begin
			@(posedge power_req_i);
			@(negedge clk_i);
			if (together_i)
			begin
				bgr_o  = 2'h3;
				core_o = 1'h1;
				repeat (BGR_WAIT) @(negedge clk_i);
			end
			else
			begin
				bgr_o = 2'h3;
				repeat (BGR_WAIT) @(negedge clk_i);
				core_o = 1'h1;
				repeat (PWD_WAIT) @(negedge clk_i);
			end
			done_o = 1'h1;
			// dropping power clears all bits at once, no ordering needed
			@(negedge power_req_i);
			@(negedge clk_i);
			{bgr_o, core_o, done_o} = 4'h0;
		end
	end
endmodule
`default_nettype wire

// *** result_fifo.sv ***
/*
 * small flip-flop fifo for conversion results, valid/ready on both sides.
 * assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module result_fifo
	import conv_ctl_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
)(
	input  wire logic                       clk_i,
	input  wire logic                       rst_b_i,
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [WIDTH-1:0]                out_data_o,
	output logic [$clog2(DEPTH):0]          level_o
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               rd;
		logic [PW-1:0]               wr;
		logic [PW:0]                 cnt;
	} fifo_state_t;

	fifo_state_t cs;
	fifo_state_t next_cs;
	logic        push;
	logic        pop;

	assign in_ready_o  = (cs.cnt != (PW+1)'(DEPTH));
	assign out_valid_o = (cs.cnt != '0);
	assign out_data_o  = cs.mem[cs.rd];
	assign level_o     = cs.cnt;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb
	begin
		next_cs = cs;
		if (push)
		begin
			next_cs.mem[cs.wr] = in_data_i;
			next_cs.wr = (cs.wr == PW'(DEPTH - 1)) ? '0 : cs.wr + 1'b1;
		end
		if (pop)
		begin
			next_cs.rd = (cs.rd == PW'(DEPTH - 1)) ? '0 : cs.rd + 1'b1;
		end
		// simultaneous push and pop leaves the count alone
		next_cs.cnt = cs.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			cs <= '0;
		else
			cs <= next_cs;
	end
endmodule
`default_nettype wire
